/* File: tb/adc_model.sv */
`timescale 1ns/1ps
module adc_model #(
	parameter int unsigned N = 20,
	parameter logic [15:0] VOLT = 16'h8000,
	parameter logic [15:0] TEMP = 16'h4400
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic adc_start,
	input wire logic adc_sel_temp,
	output logic [15:0] adc_data
);
	int unsigned cnt;
	// toggles outside a conversion so a stale sample never matches
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt <= 0;
			adc_data <= 16'h0000;
		end
		else
		begin
			cnt <= adc_start ? N : (cnt != 0 ? cnt - 1 : 0);
			adc_data <= (adc_start || cnt > 1) ? (adc_sel_temp ? TEMP : VOLT) : ~adc_data;
		end
	end
endmodule // adc_model

/* File: tb/gauge_control_sequencer_tb.sv */
`timescale 1ns/1ps
module gauge_control_sequencer_tb;
	localparam int unsigned CONV = 20;
	localparam logic [15:0] VOLT = 16'h8000;
	localparam logic [15:0] TEMP = 16'h4400;
	logic mclk, rst_b, ctrl_wr, acc_wr, status_clr, ara_hit, step_up, step_dn, pin_in;
	logic [7:0] ctrl_wdata;
	logic [15:0] acc_wdata, adc_data, acc, voltage_result, temp_result;
	gauge_pkg::ctrl_t ctrl_rdata;
	gauge_pkg::stat_t status;
	gauge_pkg::lim_t limits;
	logic analog_on, adc_start, adc_sel_temp, pin_out, pin_oe_b, alert_pending;
	int err_count = 0;
	int checked = 0;

	gauge_control_sequencer #(.CONV_CYCLES(CONV), .SCAN_IDLE_CYCLES(30)) i_dut (
		.mclk, .rst_b, .ctrl_wr, .ctrl_wdata, .ctrl_rdata, .acc_wr, .acc_wdata,
		.charge_accumulator(acc), .limits, .status_clr, .status, .ara_hit, .step_up,
		.step_dn, .analog_on, .adc_start, .adc_sel_temp, .adc_data, .voltage_result,
		.temp_result, .pin_in, .pin_out, .pin_oe_b, .alert_pending
	);
	adc_model #(.N(CONV), .VOLT(VOLT), .TEMP(TEMP)) i_adc (
		.mclk, .rst_b, .adc_start, .adc_sel_temp, .adc_data
	);

	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// pin config 11 is never written
	task automatic wr(input logic [7:0] d);
		ctrl_wdata = d;
		ctrl_wr = 1'b1;
		cyc(1);
		ctrl_wr = 1'b0;
		cyc(1);
	endtask

	task automatic load(input logic [15:0] d);
		acc_wdata = d;
		acc_wr = 1'b1;
		cyc(1);
		acc_wr = 1'b0;
		cyc(1);
	endtask

	task automatic steps(input logic up, input int n);
		step_up = up;
		step_dn = !up;
		cyc(n);
		step_up = 1'b0;
		step_dn = 1'b0;
		cyc(2);
	endtask

	task automatic wait_start(output int n);
		n = 0;
		while (adc_start !== 1'b1 && n < 200)
		begin
			cyc(1);
			n++;
		end
		chk(adc_start, 1'b1);
		// step past the pulse so the next call waits for a fresh one
		cyc(1);
	endtask

	task automatic wait_sleep(output int n);
		n = 0;
		while (ctrl_rdata.mode !== gauge_pkg::MODE_SLEEP && n < 200)
		begin
			cyc(1);
			n++;
		end
	endtask

	task automatic t_single;
		int n;
		wr(8'h84);
		wait_start(n);
		chk(adc_sel_temp, 1'b0);
		wait_sleep(n);
		chk(16'(n), 16'(CONV - 1));
		chk(voltage_result, VOLT);
		wr(8'h44);
		wait_start(n);
		chk(adc_sel_temp, 1'b1);
		wait_sleep(n);
		chk(temp_result, TEMP);
		// rewrite mid-conversion: voltage must finish before temperature
		wr(8'h84);
		wait_start(n);
		wr(8'h44);
		wait_start(n);
		chk(adc_sel_temp, 1'b1);
		chk(n >= CONV - 2, 1'b1);
		chk(ctrl_rdata.mode, gauge_pkg::MODE_TEMP);
		wait_sleep(n);
		cyc(CONV + 5);
		chk(ctrl_rdata.mode, gauge_pkg::MODE_SLEEP);
		$display("test single done");
	endtask

	task automatic t_auto;
		int n;
		wr(8'hc4);
		wait_start(n);
		chk(adc_sel_temp, 1'b0);
		wait_start(n);
		chk(adc_sel_temp, 1'b1);
		wait_start(n);
		chk(adc_sel_temp, 1'b0);
		chk(n >= CONV + 29, 1'b1);
		chk(ctrl_rdata.mode, gauge_pkg::MODE_AUTO);
		wr(8'h04);
		cyc(CONV + 40);
		chk(ctrl_rdata.mode, gauge_pkg::MODE_SLEEP);
		$display("test auto done");
	endtask

	task automatic t_count;
		logic [15:0] a;
		for (int p = 0; p < 3; p++)
		begin
			wr(8'h04 | 8'(p << 3));
			a = acc;
			steps(1'b1, (8 << p) - 1);
			chk(acc, a);
			steps(1'b1, 1);
			chk(acc, a + 16'h1);
			steps(1'b0, 1);
			chk(acc, a);
			// a down wrap leaves a full residue; one up step empties it again
			steps(1'b1, 1);
			chk(acc, a + 16'h1);
		end
		wr(8'h04);
		steps(1'b1, 5);
		a = acc;
		wr(8'h05);
		chk(analog_on, 1'b0);
		steps(1'b1, 8);
		chk(acc, a);
		chk(ctrl_rdata, 8'h05);
		wr(8'h04);
		steps(1'b1, 7);
		chk(acc, a);
		steps(1'b1, 1);
		chk(acc, a + 16'h1);
		$display("test counter done");
	endtask

	task automatic t_pin;
		int n;
		wr(8'h00);
		load(16'hffff);
		steps(1'b1, 8);
		chk(acc, 16'hffff);
		chk(status.acc_ovf, 1'b1);
		chk(pin_oe_b, 1'b1);
		load(16'h0000);
		steps(1'b0, 1);
		chk(acc, 16'h0000);
		wr(8'h02);
		load(16'h1234);
		pin_in = 1'b1;
		cyc(2);
		chk(acc, 16'hffff);
		steps(1'b0, 16);
		chk(acc, 16'hffff);
		pin_in = 1'b0;
		limits.volt_hi = 8'h70;
		wr(8'h84);
		wait_start(n);
		wait_sleep(n);
		cyc(1);
		chk(status.volt_alert, 1'b1);
		chk(pin_oe_b, 1'b0);
		ara_hit = 1'b1;
		cyc(1);
		ara_hit = 1'b0;
		cyc(1);
		chk(pin_oe_b, 1'b1);
		limits.volt_hi = 8'hff;
		$display("test pin done");
	endtask

	task automatic t_limits;
		int n;
		limits.temp_lo = 8'h50;
		wr(8'h44);
		wait_start(n);
		wait_sleep(n);
		cyc(1);
		chk(status.temp_alert, 1'b1);
		chk(alert_pending, 1'b1);
		chk(pin_out, 1'b0);
		limits.temp_lo = 8'h00;
		limits.chg_hi = 16'h8000;
		cyc(1);
		chk(status.chg_hi, 1'b1);
		limits.chg_hi = 16'hffff;
		ara_hit = 1'b1;
		status_clr = 1'b1;
		cyc(1);
		ara_hit = 1'b0;
		status_clr = 1'b0;
		cyc(1);
		chk(status, 16'h0000);
		chk(alert_pending, 1'b0);
		chk(pin_oe_b, 1'b1);
		$display("test limits done");
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		#100000;
		err_count++;
		summarize;
	end

	initial
	begin
		rst_b = 1'b0;
		ctrl_wr = 1'b0;
		ctrl_wdata = 8'h00;
		acc_wr = 1'b0;
		acc_wdata = 16'h0000;
		status_clr = 1'b0;
		ara_hit = 1'b0;
		step_up = 1'b0;
		step_dn = 1'b0;
		pin_in = 1'b0;
		limits = {16'hffff, 16'h0000, 8'hff, 8'h00, 8'hff, 8'h00};
		cyc(4);
		rst_b = 1'b1;
		chk(ctrl_rdata, 8'h3c);
		chk(acc, 16'h7fff);
		chk(pin_oe_b, 1'b1);
		$display("test reset done");
		t_single;
		t_auto;
		t_count;
		t_pin;
		t_limits;
		summarize;
	end
endmodule // gauge_control_sequencer_tb

/* File: verilog/gauge_control_sequencer.sv */
`timescale 1ns/1ps
// Summary of operation
// - auto mode: volt, temp, idle, repeat
// - mode 10 runs one voltage conversion
// - mode 01 runs one temperature conversion
// - single conversion done clears mode to sleep
// - mode 00 sleeps; resets to 00
// - auto mode never cleared by hardware
// - running conversion finishes before new mode
// - each conversion lasts ten milliseconds
// - result loads into matching result register
// - out-of-limit result sets flag; alert only with pin config 10 or 11
// - prescaler is two to field value
// - prescaler times eight internal steps per count
// - pin config 10 drives alert low
// - alert response releases the pin
// - pin config 01 high input forces full
// - pin config 00 disables the pin
// - shutdown stops analog, registers kept
// - shutdown discards fractional charge residue
// - prescaler wrap steps accumulator by one
// - accumulator saturates and flags overflow
module gauge_control_sequencer #(
	parameter int unsigned CONV_CYCLES = gauge_pkg::CONV_CYCLES,
	parameter int unsigned SCAN_IDLE_CYCLES = gauge_pkg::SCAN_IDLE_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	output gauge_pkg::ctrl_t ctrl_rdata,
	input wire logic acc_wr,
	input wire logic [15:0] acc_wdata,
	output logic [15:0] charge_accumulator,
	input gauge_pkg::lim_t limits,
	input wire logic status_clr,
	output gauge_pkg::stat_t status,
	input wire logic ara_hit,
	input wire logic step_up,
	input wire logic step_dn,
	output logic analog_on,
	output logic adc_start,
	output logic adc_sel_temp,
	input wire logic [15:0] adc_data,
	output logic [15:0] voltage_result,
	output logic [15:0] temp_result,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe_b,
	output logic alert_pending
);

	localparam logic [31:0] CONV_LAST = 32'(CONV_CYCLES - 1);
	localparam logic [31:0] SCAN_LAST = 32'(SCAN_IDLE_CYCLES - 1);

	gauge_pkg::ctrl_t ctrl_reg, ctrl_next;
	gauge_pkg::seq_state_t state_reg, state_next;
	gauge_pkg::adc_mode_t conv_mode_reg, conv_mode_next;
	gauge_pkg::stat_t stat_reg, stat_next;
	logic [31:0] timer_reg, timer_next;
	logic conv_temp_reg, conv_temp_next;
	logic conv_auto_reg, conv_auto_next;
	logic start_reg, start_next;
	logic clear_mode;
	logic [9:0] pre_reg, pre_next;
	logic [15:0] acc_reg, acc_next;
	logic [15:0] volt_reg, temp_reg;
	logic chg_over_reg, chg_under_reg;
	logic alert_reg, alert_next;
	logic oe_b_reg;

	wire gauge_pkg::adc_mode_t mode = ctrl_reg.mode;
	wire logic shdn = ctrl_reg.shutdown;
	wire logic conv_done = state_reg == gauge_pkg::ST_CONV && !shdn && timer_reg == CONV_LAST;
	wire logic [31:0] timer_inc = timer_reg + 32'h1;

	// host write beats the self-clear so a fresh mode is never lost
	wire gauge_pkg::ctrl_t ctrl_cleared = '{mode: gauge_pkg::MODE_SLEEP,
		prescale: ctrl_reg.prescale, pin: ctrl_reg.pin, shutdown: ctrl_reg.shutdown};
	assign ctrl_next = ctrl_wr ? gauge_pkg::ctrl_t'(ctrl_wdata) :
		clear_mode ? ctrl_cleared : ctrl_reg;

	always_comb
	begin
		state_next = state_reg;
		timer_next = timer_reg;
		conv_temp_next = conv_temp_reg;
		conv_auto_next = conv_auto_reg;
		conv_mode_next = conv_mode_reg;
		start_next = 1'b0;
		clear_mode = 1'b0;
		unique case (state_reg)
			gauge_pkg::ST_IDLE:
				if (!shdn && mode != gauge_pkg::MODE_SLEEP)
				begin
					state_next = gauge_pkg::ST_CONV;
					timer_next = 32'h0;
					conv_temp_next = mode == gauge_pkg::MODE_TEMP;
					conv_auto_next = mode == gauge_pkg::MODE_AUTO;
					conv_mode_next = mode;
					start_next = 1'b1;
				end
			gauge_pkg::ST_CONV:
				// mode is only looked at once the conversion is over
				if (conv_done)
				begin
					timer_next = 32'h0;
					if (conv_auto_reg && !conv_temp_reg && mode == gauge_pkg::MODE_AUTO)
					begin
						conv_temp_next = 1'b1;
						start_next = 1'b1;
					end
					else if (conv_auto_reg && mode == gauge_pkg::MODE_AUTO)
						state_next = gauge_pkg::ST_WAIT;
					else
					begin
						state_next = gauge_pkg::ST_IDLE;
						clear_mode = !conv_auto_reg && mode == conv_mode_reg;
					end
				end
				else if (!shdn)
					timer_next = timer_inc;
			gauge_pkg::ST_WAIT:
				if (mode != gauge_pkg::MODE_AUTO)
					state_next = gauge_pkg::ST_IDLE;
				else if (!shdn)
				begin
					if (timer_reg == SCAN_LAST)
					begin
						state_next = gauge_pkg::ST_CONV;
						timer_next = 32'h0;
						conv_temp_next = 1'b0;
						conv_auto_next = 1'b1;
						conv_mode_next = mode;
						start_next = 1'b1;
					end
					else
						timer_next = timer_inc;
				end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			ctrl_reg <= gauge_pkg::CTRL_RESET;
			state_reg <= gauge_pkg::ST_IDLE;
			timer_reg <= 32'h0;
			conv_temp_reg <= 1'b0;
			conv_auto_reg <= 1'b0;
			conv_mode_reg <= gauge_pkg::MODE_SLEEP;
			start_reg <= 1'b0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			state_reg <= state_next;
			timer_reg <= timer_next;
			conv_temp_reg <= conv_temp_next;
			conv_auto_reg <= conv_auto_next;
			conv_mode_reg <= conv_mode_next;
			start_reg <= start_next;
		end

	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			volt_reg <= 16'h0;
			temp_reg <= 16'h0;
		end
		else if (conv_done)
		begin
			if (conv_temp_reg)
				temp_reg <= adc_data;
			else
				volt_reg <= adc_data;
		end

	// coulomb counter: M*8 internal steps per accumulator count
	wire logic [10:0] pre_span = gauge_pkg::INTERNAL_STEPS << ctrl_reg.prescale;
	wire logic [9:0] pre_top = 10'(pre_span - 11'h1);
	wire logic up = step_up && !step_dn && !shdn;
	wire logic dn = step_dn && !step_up && !shdn;
	// >= covers a residue left above a newly lowered prescaler
	wire logic wrap_up = up && pre_reg >= pre_top;
	wire logic wrap_dn = dn && pre_reg == 10'h0;

	assign pre_next = shdn ? 10'h0 :
		wrap_up ? 10'h0 :
		wrap_dn ? pre_top :
		up ? 10'(pre_reg + 10'h1) :
		dn ? 10'(pre_reg - 10'h1) : pre_reg;

	// pin config 11 turns on both functions; software must avoid it
	wire logic cc_mode = ctrl_reg.pin[0];
	wire logic alert_mode = ctrl_reg.pin[1];
	wire logic full_force = cc_mode && pin_in;
	wire logic acc_inc = wrap_up && acc_reg != gauge_pkg::ACR_FULL;
	wire logic acc_dec = wrap_dn && acc_reg != gauge_pkg::ACR_EMPTY;

	// a step racing a host write is dropped; shutdown first when loading
	assign acc_next = full_force ? gauge_pkg::ACR_FULL :
		acc_wr ? acc_wdata :
		acc_inc ? 16'(acc_reg + 16'h1) :
		acc_dec ? 16'(acc_reg - 16'h1) : acc_reg;

	wire logic acc_hit = !full_force && !acc_wr &&
		((wrap_up && acc_next == gauge_pkg::ACR_FULL) ||
		(wrap_dn && acc_next == gauge_pkg::ACR_EMPTY));

	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			pre_reg <= 10'h0;
			acc_reg <= gauge_pkg::ACR_RESET;
		end
		else
		begin
			pre_reg <= pre_next;
			acc_reg <= acc_next;
		end

	// limit checks: charge is watched always, voltage and temp per result
	wire logic chg_over = acc_reg > limits.chg_hi;
	wire logic chg_under = acc_reg < limits.chg_lo;
	wire logic volt_ev = conv_done && !conv_temp_reg &&
		(adc_data[15:8] > limits.volt_hi || adc_data[15:8] < limits.volt_lo);
	wire logic temp_ev = conv_done && conv_temp_reg &&
		(adc_data[15:8] > limits.temp_hi || adc_data[15:8] < limits.temp_lo);

	// set wins over a read-clear in the same cycle
	wire logic keep = !status_clr;
	assign stat_next.acc_ovf = acc_hit || (stat_reg.acc_ovf && keep);
	assign stat_next.temp_alert = temp_ev || (stat_reg.temp_alert && keep);
	assign stat_next.chg_hi = chg_over || (stat_reg.chg_hi && keep);
	assign stat_next.chg_lo = chg_under || (stat_reg.chg_lo && keep);
	assign stat_next.volt_alert = volt_ev || (stat_reg.volt_alert && keep);

	// charge alert fires on the crossing, else it would re-arm every cycle
	wire logic alert_ev = acc_hit || volt_ev || temp_ev ||
		(chg_over && !chg_over_reg) || (chg_under && !chg_under_reg);
	assign alert_next = alert_mode && (alert_ev || (alert_reg && !ara_hit));

	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			stat_reg <= '0;
			chg_over_reg <= 1'b0;
			chg_under_reg <= 1'b0;
			alert_reg <= 1'b0;
			oe_b_reg <= 1'b1;
		end
		else
		begin
			stat_reg <= stat_next;
			chg_over_reg <= chg_over;
			chg_under_reg <= chg_under;
			alert_reg <= alert_next;
			oe_b_reg <= !alert_next;
		end

	assign ctrl_rdata = ctrl_reg;
	assign charge_accumulator = acc_reg;
	assign status = stat_reg;
	assign analog_on = !shdn;
	assign adc_start = start_reg;
	assign adc_sel_temp = conv_temp_reg;
	assign voltage_result = volt_reg;
	assign temp_result = temp_reg;
	assign pin_out = 1'b0;
	assign pin_oe_b = oe_b_reg;
	assign alert_pending = alert_reg;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	logic [31:0] conv_age_reg;
	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
			conv_age_reg <= 32'h0;
		else if (start_next)
			conv_age_reg <= 32'h0;
		else if (state_reg == gauge_pkg::ST_CONV && !shdn)
			conv_age_reg <= conv_age_reg + 32'h1;

	a_conv_length: assert property (conv_done |-> conv_age_reg == CONV_LAST)
		else $error("conversion length wrong");
	a_auto_kept: assert property (mode == gauge_pkg::MODE_AUTO && !ctrl_wr
		|=> mode == gauge_pkg::MODE_AUTO)
		else $error("auto mode changed without host write");
	a_single_clears: assert property (conv_done && !conv_auto_reg && !ctrl_wr
		&& mode == conv_mode_reg |=> mode == gauge_pkg::MODE_SLEEP)
		else $error("single conversion did not clear mode");
	a_volt_load: assert property (conv_done && !conv_temp_reg
		|=> voltage_result == $past(adc_data) && $stable(temp_result))
		else $error("voltage result not loaded");
	a_temp_load: assert property (conv_done && conv_temp_reg
		|=> temp_result == $past(adc_data) && $stable(voltage_result))
		else $error("temperature result not loaded");
	a_auto_temp_next: assert property (conv_done && conv_auto_reg
		&& !conv_temp_reg && mode == gauge_pkg::MODE_AUTO
		|=> adc_start && adc_sel_temp)
		else $error("auto scan skipped temperature");
	a_sleep_quiet: assert property (state_reg == gauge_pkg::ST_IDLE
		&& mode == gauge_pkg::MODE_SLEEP |=> !adc_start)
		else $error("conversion started in sleep");
	a_single_volt: assert property (state_reg == gauge_pkg::ST_IDLE && !shdn
		&& mode == gauge_pkg::MODE_VOLT |=> adc_start && !adc_sel_temp)
		else $error("voltage conversion not started");
	a_single_temp: assert property (state_reg == gauge_pkg::ST_IDLE && !shdn
		&& mode == gauge_pkg::MODE_TEMP |=> adc_start && adc_sel_temp)
		else $error("temperature conversion not started");
	a_shdn_no_start: assert property (shdn |=> !adc_start)
		else $error("conversion started in shutdown");
	a_full_force: assert property (cc_mode && pin_in
		|=> charge_accumulator == gauge_pkg::ACR_FULL)
		else $error("charge complete did not force full");
	a_acc_step: assert property (wrap_up && !full_force && !acc_wr
		&& acc_reg != gauge_pkg::ACR_FULL
		|=> charge_accumulator == 16'($past(acc_reg) + 16'h1))
		else $error("accumulator did not count up");
	a_saturate_top: assert property (wrap_up && !acc_wr
		&& !full_force && acc_reg == gauge_pkg::ACR_FULL
		|=> charge_accumulator == gauge_pkg::ACR_FULL && status.acc_ovf)
		else $error("accumulator wrapped past top");
	a_saturate_bottom: assert property (wrap_dn && !acc_wr
		&& !full_force && acc_reg == gauge_pkg::ACR_EMPTY
		|=> charge_accumulator == gauge_pkg::ACR_EMPTY && status.acc_ovf)
		else $error("accumulator wrapped past bottom");
	a_shdn_hold: assert property (shdn && !acc_wr && !full_force
		|=> $stable(charge_accumulator) && pre_reg == 10'h0)
		else $error("accumulator moved in shutdown");
	a_alert_drive: assert property (alert_mode && alert_ev |=> !pin_oe_b)
		else $error("alert pin not driven");
	a_alert_release: assert property (ara_hit && !alert_ev |=> pin_oe_b)
		else $error("alert pin not released");
	a_pin_quiet: assert property (!alert_mode |=> pin_oe_b && !alert_pending)
		else $error("alert pin driven outside alert mode");

	c_auto_temp: cover property (conv_done && conv_auto_reg && conv_temp_reg);
	c_single_volt: cover property (conv_done && !conv_auto_reg && !conv_temp_reg);
	c_saturate: cover property (acc_hit);
	c_alert_cycle: cover property (alert_reg ##1 ara_hit ##1 pin_oe_b);
	c_scan_wait: cover property (state_reg == gauge_pkg::ST_WAIT && timer_reg == SCAN_LAST);

endmodule // gauge_control_sequencer

/* File: verilog/gauge_pkg.sv */
package gauge_pkg;

	typedef enum logic [1:0] {
		MODE_SLEEP = 2'h0,
		MODE_TEMP = 2'h1,
		MODE_VOLT = 2'h2,
		MODE_AUTO = 2'h3
	} adc_mode_t;

	typedef enum logic [1:0] {
		PIN_OFF = 2'h0,
		PIN_FULL = 2'h1,
		PIN_ALERT = 2'h2,
		PIN_BOTH = 2'h3
	} pin_cfg_t;

	// bit 7:6 mode, 5:3 prescale, 2:1 pin config, 0 shutdown
	typedef struct packed {
		adc_mode_t mode;
		logic [2:0] prescale;
		pin_cfg_t pin;
		logic shutdown;
	} ctrl_t;

	typedef struct packed {
		logic [15:0] chg_hi;
		logic [15:0] chg_lo;
		logic [7:0] volt_hi;
		logic [7:0] volt_lo;
		logic [7:0] temp_hi;
		logic [7:0] temp_lo;
	} lim_t;

	// same order as status bits 5..1
	typedef struct packed {
		logic acc_ovf;
		logic temp_alert;
		logic chg_hi;
		logic chg_lo;
		logic volt_alert;
	} stat_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_CONV = 3'h2,
		ST_WAIT = 3'h4
	} seq_state_t;

	localparam ctrl_t CTRL_RESET = 8'h3c;
	localparam logic [15:0] ACR_RESET = 16'h7fff;
	localparam logic [15:0] ACR_FULL = 16'hffff;
	localparam logic [15:0] ACR_EMPTY = 16'h0000;
	localparam logic [10:0] INTERNAL_STEPS = 11'h008;

	localparam int unsigned CLK_KHZ = 200000;
	localparam int unsigned CONV_TIME_MS = 10;
	localparam int unsigned SCAN_IDLE_MS = 2000;
	localparam int unsigned CONV_CYCLES = CONV_TIME_MS * CLK_KHZ;
	localparam int unsigned SCAN_IDLE_CYCLES = SCAN_IDLE_MS * CLK_KHZ;

endpackage
